// ### design/pfd_diag_mem.sv
// latest diagnostic word of each input/output module, one entry per module; of same-cycle reports only the lowest index is written
// assumes one writer and one reader on the shared clock; read data registered
`timescale 1ns/1ps
module pfd_diag_mem #(
  parameter int W = 9,
  parameter int DEPTH = 4,
  parameter int AW = 2
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  input wire logic i_ce,
  input wire logic i_we,
  input wire logic [AW-1:0] i_waddr,
  input wire logic [W-1:0] i_wdata,
  input wire logic i_re,
  input wire logic [AW-1:0] i_raddr,
  output logic [W-1:0] o_rdata
);
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [W-1:0] rdata;
  } pfd_mem_t;

  pfd_mem_t r;
  pfd_mem_t n;

  always_comb begin
    n = r;
    // read before write: a same-cycle write shows on the next read
    if (i_re) begin
      n.rdata = r.mem[i_raddr];
    end
    if (i_we) begin
      n.mem[i_waddr] = i_wdata;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      r <= '0;
    end else if (i_ce) begin
      r <= n;
    end
  end

  assign o_rdata = r.rdata;
endmodule : pfd_diag_mem

// ### design/pfd_main.sv
// central logic module fault aggregation and safe-state control
// assumes module reports, link status and control outputs are synchronous to i_ref_clk
`timescale 1ns/1ps
module pfd_main import pfd_pkg::*; #(
  parameter int N_MOD = 4,
  parameter int DW = 8
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  input wire logic i_ce,
  input wire logic [N_MOD-1:0] i_mod_present,
  input wire logic [N_MOD-1:0] i_mod_is_out,
  input wire logic [N_MOD-1:0] i_mod_qual,
  input wire logic [N_MOD-1:0] i_mod_link_ok,
  input wire logic [N_MOD-1:0] i_mod_diag_vld,
  input wire logic [N_MOD*DW-1:0] i_mod_diag,
  input wire logic [N_MOD-1:0] i_mod_diag_par,
  input wire logic i_hw_st_fail,
  input wire logic i_if_st_fail,
  input wire logic i_pl_fault,
  input wire logic [N_MOD-1:0] i_ctl_out,
  output logic [N_MOD-1:0] o_out,
  output logic [N_MOD-1:0] o_mod_safe,
  output logic o_safe_halt,
  output logic o_gen_fault,
  output logic o_alarm,
  output logic o_usr_vld,
  output logic [$clog2(N_MOD)-1:0] o_usr_mod,
  output logic [DW-3:0] o_usr_code,
  output logic o_maintenance_test_station_txd
);
  localparam int MW = $clog2(N_MOD);
  localparam int IW = $clog2(N_MOD + 1);
  localparam int FW = DW + 3;
  localparam int BW = $clog2(FW + 1);
  localparam int VW = $clog2(BIT_CYC);
  localparam int SW = $clog2(START_CYC);

  typedef struct packed {
    pfd_state_t st;
    pfd_tx_t tx_ph;
    logic [N_MOD-1:0] out;
    logic [N_MOD-1:0] mod_safe;
    logic [N_MOD-1:0] lost;
    logic own_sev;
    logic own_mid;
    logic par_err;
    logic mem_err;
    logic cmp_err;
    logic nonsafe;
    logic usr_seen;
    logic gen_fault;
    logic halt;
    logic usr_vld;
    logic [MW-1:0] usr_mod;
    logic [DW-3:0] usr_code;
    logic [SW-1:0] start_cnt;
    logic txd;
    logic [IW-1:0] tx_idx;
    logic [BW-1:0] tx_bit;
    logic [VW-1:0] tx_div;
    logic [FW-1:0] tx_sh;
  } pfd_main_t;

  pfd_main_t r;
  pfd_main_t n;

  logic [DW-1:0] w_word [N_MOD];
  logic [1:0] w_cls [N_MOD];
  logic [N_MOD-1:0] par_ok;
  logic [N_MOD-1:0] sev_hit;
  logic [N_MOD-1:0] mid_hit;
  logic [N_MOD-1:0] usr_rpt;
  logic [N_MOD-1:0] out_lost;
  logic [N_MOD-1:0] in_lost;
  logic [N_MOD-1:0] bad_mod;
  logic [N_MOD-1:0] usr_hit;
  logic [1:0] cls_a;
  logic [1:0] cls_b;
  logic [1:0] own_cls;
  logic [DW-1:0] own_word;
  logic [DW:0] rd_word;
  logic [DW:0] fr_word;
  logic mem_we;
  logic [MW-1:0] mem_waddr;
  logic [DW:0] mem_wdata;

  // per-module decode of reports and link state
  for (genvar gi = 0; gi < N_MOD; gi++) begin : g_mod
    assign w_word[gi] = i_mod_diag[gi*DW +: DW];
    assign w_cls[gi] = w_word[gi][DW-1 -: 2];
    assign par_ok[gi] = (^w_word[gi]) == i_mod_diag_par[gi];
    assign sev_hit[gi] = i_mod_diag_vld[gi] && par_ok[gi] && w_cls[gi] == CLS_SEV;
    assign mid_hit[gi] = i_mod_diag_vld[gi] && par_ok[gi] && w_cls[gi] == CLS_MID;
    assign usr_rpt[gi] = i_mod_diag_vld[gi] && par_ok[gi] && w_cls[gi] == CLS_USER;
    assign out_lost[gi] = i_mod_present[gi] && i_mod_is_out[gi] && !i_mod_link_ok[gi];
    assign in_lost[gi] = i_mod_present[gi] && !i_mod_is_out[gi] && !i_mod_link_ok[gi];
    assign bad_mod[gi] = i_mod_present[gi] && !i_mod_qual[gi];
    assign usr_hit[gi] = usr_rpt[gi] || (in_lost[gi] && !r.lost[gi]);
  end

  // processing check: two independent reductions must agree
  always_comb begin
    cls_a = CLS_NONE;
    for (int i = 0; i < N_MOD; i++) begin
      if (i_mod_diag_vld[i] && par_ok[i] && w_cls[i] > cls_a) begin
        cls_a = w_cls[i];
      end
    end
    cls_b = (|sev_hit) ? CLS_SEV : (|mid_hit) ? CLS_MID : (|usr_rpt) ? CLS_USER : CLS_NONE;
  end

  // store the latest word per module; only the lowest index is written when several arrive
  always_comb begin
    mem_we = 1'b0;
    mem_waddr = '0;
    mem_wdata = '0;
    for (int i = N_MOD - 1; i >= 0; i--) begin
      if (i_mod_diag_vld[i] && par_ok[i]) begin
        mem_we = 1'b1;
        mem_waddr = MW'(i);
        mem_wdata = {i_mod_diag_par[i], w_word[i]};
      end
    end
  end

  // own class is the worst flag held
  always_comb begin
    own_cls = r.own_sev ? CLS_SEV : r.own_mid ? CLS_MID : r.usr_seen ? CLS_USER : CLS_NONE;
    own_word = '0;
    own_word[DW-1 -: 2] = own_cls;
    own_word[FLG_SAFE] = |r.mod_safe;
    own_word[FLG_LOST] = |r.lost;
    own_word[FLG_PAR] = r.par_err;
    own_word[FLG_MEM] = r.mem_err;
    own_word[FLG_CMP] = r.cmp_err;
    own_word[FLG_NONSAFE] = r.nonsafe;
    fr_word = (r.tx_idx == IW'(N_MOD)) ? {^own_word, own_word} : rd_word;
  end

  pfd_diag_mem #(
    .W(DW + 1),
    .DEPTH(N_MOD),
    .AW(MW)
  ) u_mem (
    .i_ref_clk(i_ref_clk),
    .i_rst_b(i_rst_b),
    .i_ce(i_ce),
    .i_we(mem_we),
    .i_waddr(mem_waddr),
    .i_wdata(mem_wdata),
    .i_re(r.tx_ph == TX_IDLE),
    .i_raddr(r.tx_idx[MW-1:0]),
    .o_rdata(rd_word)
  );

  always_comb begin
    n = r;
    n.usr_vld = 1'b0;
    // intermediate report forces that module safe; severe likewise
    n.mod_safe = r.mod_safe | sev_hit | mid_hit;
    n.lost = r.lost | out_lost | in_lost;
    n.par_err = r.par_err | (|(i_mod_diag_vld & ~par_ok));
    n.cmp_err = r.cmp_err | (cls_a != cls_b);
    if (r.tx_ph == TX_LOAD && r.tx_idx < IW'(N_MOD) && (^rd_word) != 1'b0) begin
      n.mem_err = 1'b1;
    end
    // logic faults and failed cross-checks are most severe
    n.own_sev = r.own_sev | i_pl_fault | n.cmp_err;
    // hardware, interface and design faults are intermediate
    n.own_mid = r.own_mid | i_hw_st_fail | i_if_st_fail | n.par_err | n.mem_err;
    // user-class faults and lost input modules go to the application; only the lowest index when several hit in one cycle
    for (int i = N_MOD - 1; i >= 0; i--) begin
      if (usr_hit[i]) begin
        n.usr_vld = 1'b1;
        n.usr_mod = MW'(i);
        n.usr_code = usr_rpt[i] ? w_word[i][DW-3:0] : '1;
        n.usr_seen = 1'b1;
      end
    end
    case (r.st)
      ST_START: begin
        // screen for unqualified modules during startup
        n.nonsafe = r.nonsafe | (|bad_mod);
        if (r.start_cnt == SW'(START_CYC - 1)) begin
          n.st = n.nonsafe ? ST_HOLD : ST_RUN;
        end else begin
          n.start_cnt = r.start_cnt + 1'b1;
        end
      end
      ST_RUN: begin
        // lost output module trips the system
        if (|out_lost) begin
          n.st = ST_HALT;
        end
      end
      ST_HOLD: begin
        n.st = ST_HOLD;
      end
      ST_HALT: begin
        n.st = ST_HALT;
      end
      default: begin
        n.st = ST_HALT;
      end
    endcase
    // own severe or intermediate fault halts from any state
    if (n.own_sev || n.own_mid) begin
      n.st = ST_HALT;
    end
    // diagnostics can only force outputs to the safe level
    n.out = (n.st == ST_RUN) ? (i_ctl_out & ~n.mod_safe) : {N_MOD{SAFE_LVL}};
    n.halt = n.st == ST_HALT;
    // one fault level for the station and user alarms
    n.gen_fault = n.own_sev | n.own_mid | n.nonsafe | n.usr_seen | (|n.mod_safe) | (|n.lost);
    // round robin over module entries, then the own word
    case (r.tx_ph)
      TX_IDLE: begin
        n.tx_ph = TX_LOAD;
      end
      TX_LOAD: begin
        n.txd = 1'b0;
        // stop bit sits above parity and data, shifted out lsb first
        n.tx_sh = FW'({1'b1, fr_word});
        n.tx_bit = BW'(1);
        n.tx_div = '0;
        n.tx_ph = TX_SEND;
      end
      TX_SEND: begin
        if (r.tx_div == VW'(BIT_CYC - 1)) begin
          n.tx_div = '0;
          if (r.tx_bit == BW'(FW)) begin
            n.tx_ph = TX_IDLE;
            n.txd = TXD_IDLE;
            n.tx_idx = (r.tx_idx == IW'(N_MOD)) ? '0 : r.tx_idx + 1'b1;
          end else begin
            n.txd = r.tx_sh[0];
            n.tx_sh = r.tx_sh >> 1;
            n.tx_bit = r.tx_bit + 1'b1;
          end
        end else begin
          n.tx_div = r.tx_div + 1'b1;
        end
      end
      default: begin
        n.tx_ph = TX_IDLE;
        n.txd = TXD_IDLE;
      end
    endcase
  end

  // frozen entirely while the enable is low
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      r <= '0;
      r.txd <= TXD_IDLE;
    end else if (i_ce) begin
      r <= n;
    end
  end

  assign o_out = r.out;
  assign o_mod_safe = r.mod_safe;
  assign o_safe_halt = r.halt;
  assign o_gen_fault = r.gen_fault;
  assign o_alarm = r.gen_fault;
  assign o_usr_vld = r.usr_vld;
  assign o_usr_mod = r.usr_mod;
  assign o_usr_code = r.usr_code;
  assign o_maintenance_test_station_txd = r.txd;

  property p_pl_trip;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
      i_ce && i_pl_fault |=> o_safe_halt && o_out == '0;
  endproperty
  a_pl_trip: assert property (p_pl_trip) else $error("logic fault did not halt");

  property p_hw_mid;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
      i_ce && i_hw_st_fail |=> o_gen_fault && o_out == '0;
  endproperty
  a_hw_mid: assert property (p_hw_mid) else $error("hw fault left outputs live");

  property p_halt_hold;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
      o_safe_halt |=> o_safe_halt && o_out == '0;
  endproperty
  a_halt_hold: assert property (p_halt_hold) else $error("safe halt was left");

  property p_out_lost;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
      i_ce && r.st == ST_RUN && (|out_lost) |=> o_safe_halt;
  endproperty
  a_out_lost: assert property (p_out_lost) else $error("output link loss no trip");

  property p_mid_safe;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
      i_ce && (|mid_hit) |=> (o_out & $past(mid_hit)) == '0;
  endproperty
  a_mid_safe: assert property (p_mid_safe) else $error("module fault not forced");

  property p_nonsafe;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
      r.nonsafe |-> o_out == '0 && r.st != ST_RUN;
  endproperty
  a_nonsafe: assert property (p_nonsafe) else $error("unqualified module ran");

  property p_par;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
      i_ce && (|(i_mod_diag_vld & ~par_ok)) |=> o_safe_halt ##1 o_safe_halt;
  endproperty
  a_par: assert property (p_par) else $error("bad report parity missed");

  property p_usr;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
      i_ce && (|usr_rpt) |=> o_usr_vld && o_gen_fault;
  endproperty
  a_usr: assert property (p_usr) else $error("user fault not passed on");

  property p_frame;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
      i_ce && r.tx_ph == TX_LOAD |=> !o_maintenance_test_station_txd;
  endproperty
  a_frame: assert property (p_frame) else $error("frame start bit missing");

  property p_worst;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
      i_ce && (i_pl_fault || i_hw_st_fail || i_if_st_fail) && (|usr_rpt)
        |=> o_safe_halt && o_out == '0;
  endproperty
  a_worst: assert property (p_worst) else $error("user fault masked own fault");

  property p_gen;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
      o_safe_halt || (|o_mod_safe) |-> o_gen_fault && o_alarm;
  endproperty
  a_gen: assert property (p_gen) else $error("fault without general flag");

  c_run: cover property (@(posedge i_ref_clk) r.st == ST_RUN && o_out != '0);
  c_halt: cover property (@(posedge i_ref_clk) $rose(o_safe_halt));
  c_hold: cover property (@(posedge i_ref_clk) r.st == ST_HOLD);
  c_usr: cover property (@(posedge i_ref_clk) o_usr_vld);
  c_own: cover property (@(posedge i_ref_clk) r.tx_ph == TX_LOAD && r.tx_idx == IW'(N_MOD));
endmodule : pfd_main

// ### design/pfd_pkg.sv
// constants, encodings and timing counts for the platform fault diagnostics block
// assumes a single 100 MHz clock domain
package pfd_pkg;
  // fault classes, most severe has the highest code
  localparam logic [1:0] CLS_NONE = 2'h0;
  localparam logic [1:0] CLS_USER = 2'h1;
  localparam logic [1:0] CLS_MID = 2'h2;
  localparam logic [1:0] CLS_SEV = 2'h3;
  // safe output level: de-energized
  localparam logic SAFE_LVL = 1'h0;
  localparam logic TXD_IDLE = 1'h1;
  // timing
  localparam int CLK_MHZ = 100;
  localparam int BIT_NS = 1000;
  localparam int BIT_CYC = (BIT_NS * CLK_MHZ + 999) / 1000;
  localparam int START_NS = 2000;
  localparam int START_CYC = (START_NS * CLK_MHZ + 999) / 1000;
  // own diagnostic word flag positions
  localparam int FLG_SAFE = 0;
  localparam int FLG_LOST = 1;
  localparam int FLG_PAR = 2;
  localparam int FLG_MEM = 3;
  localparam int FLG_CMP = 4;
  localparam int FLG_NONSAFE = 5;
  localparam int FLG_W = 6;

  typedef enum logic [1:0] {
    ST_START = 2'b00,
    ST_RUN = 2'b01,
    ST_HOLD = 2'b10,
    ST_HALT = 2'b11
  } pfd_state_t;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_LOAD = 2'b01,
    TX_SEND = 2'b10
  } pfd_tx_t;
endpackage : pfd_pkg

// ### testbench/pfd_maintenance_test_station_rx.sv
// maintenance station receiver model, decodes the one-way diagnostic line
// assumes frames of start, DW data bits lsb first, even parity, stop
`timescale 1ns/1ps
module pfd_maintenance_test_station_rx import pfd_pkg::*; #(
  parameter int DW = 8
) (
  input wire logic i_ref_clk,
  input wire logic i_rxd,
  output logic [DW-1:0] o_word,
  output logic o_vld,
  output int o_bad
);
  // frame decode
  // samples mid-bit, so edge races with the sender never matter
  initial begin
    o_vld = 1'h0;
    o_bad = 0;
    o_word = '0;
    forever begin
      @(negedge i_rxd);
      repeat (BIT_CYC / 2) @(posedge i_ref_clk);
      if (i_rxd !== 1'h0) o_bad++;
      for (int b = 0; b < DW; b++) begin
        repeat (BIT_CYC) @(posedge i_ref_clk);
        o_word[b] = i_rxd;
      end
      repeat (BIT_CYC) @(posedge i_ref_clk);
      if (i_rxd !== ^o_word) o_bad++;
      repeat (BIT_CYC) @(posedge i_ref_clk);
      if (i_rxd !== 1'h1) o_bad++;
      o_vld = 1'h1;
      @(posedge i_ref_clk);
      o_vld = 1'h0;
    end
  end
endmodule : pfd_maintenance_test_station_rx

// ### testbench/tb.sv
// self-checking bench for the central fault aggregation block
// assumes modules 0,1 are output modules and 2,3 input modules
`timescale 1ns/1ps
module tb import pfd_pkg::*;;
  logic clk = 1'h0;
  logic rst_b = 1'h0;
  logic ce = 1'h1;
  logic hw = 1'h0;
  logic ifst = 1'h0;
  logic pl = 1'h0;
  logic [3:0] pres = 4'hF;
  logic [3:0] isout = 4'h3;
  logic [3:0] qual = 4'hF;
  logic [3:0] lnk = 4'hF;
  logic [3:0] vld = 4'h0;
  logic [3:0] par = 4'h0;
  logic [3:0] ctl = 4'hF;
  logic [31:0] diag = 32'h0;
  logic [3:0] out, msafe;
  logic halt, gen, alarm, uvld, txd, rvld;
  logic [1:0] umod;
  logic [5:0] ucode;
  logic [7:0] rword;
  int rbad;
  int n_fail = 0;
  int comparisons = 0;

  always #5 clk = ~clk;

  pfd_main dut (.i_ref_clk(clk), .i_rst_b(rst_b), .i_ce(ce), .i_mod_present(pres),
    .i_mod_is_out(isout), .i_mod_qual(qual), .i_mod_link_ok(lnk), .i_mod_diag_vld(vld),
    .i_mod_diag(diag), .i_mod_diag_par(par), .i_hw_st_fail(hw), .i_if_st_fail(ifst),
    .i_pl_fault(pl), .i_ctl_out(ctl), .o_out(out), .o_mod_safe(msafe),
    .o_safe_halt(halt), .o_gen_fault(gen), .o_alarm(alarm), .o_usr_vld(uvld),
    .o_usr_mod(umod), .o_usr_code(ucode), .o_maintenance_test_station_txd(txd));

  pfd_maintenance_test_station_rx rx (.i_ref_clk(clk), .i_rxd(txd), .o_word(rword), .o_vld(rvld),
    .o_bad(rbad));

  task complete_run;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : complete_run

  task step;
    @(posedge clk);
    #1;
  endtask : step

  task chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task rst(input logic [3:0] q);
    qual = q;
    rst_b = 1'h0;
    repeat (2) step;
    rst_b = 1'h1;
    repeat (START_CYC + 3) step;
  endtask : rst

  task send(input int i, input logic [7:0] w, input logic bad);
    vld[i] = 1'h1;
    diag[i*8 +: 8] = w;
    par[i] = ^w ^ bad;
    step;
    vld = 4'h0;
  endtask : send

  // bounded wait for the user event pulse
  task wait_usr;
    int k;
    for (k = 0; k < 4 && uvld !== 1'h1; k++) step;
    if (k == 4) begin
      n_fail++;
      $display("ERROR %0t no user event", $time);
      complete_run;
    end
  endtask : wait_usr

  task t_startup;
    rst_b = 1'h0;
    repeat (2) step;
    chk(out, 4'h0, "reset out");
    chk({halt, gen, alarm, uvld, txd}, 5'h01, "reset flags");
    rst_b = 1'h1;
    repeat (START_CYC - 10) step;
    chk(out, 4'h0, "startup out");
    repeat (13) step;
    chk(out, ctl, "run out");
    chk(gen, 1'h0, "run gen");
  endtask : t_startup

  task t_serial;
    int k;
    send(0, {CLS_USER, 6'h2A}, 1'h0);
    for (k = 0; k < 12000 && !(rvld === 1'h1 && rword === {CLS_USER, 6'h2A}); k++) step;
    chk(k < 12000, 1'h1, "module word on line");
    if (k == 12000) complete_run;
    // own word: user class seen, every other flag clear
    for (k = 0; k < 12000 && !(rvld === 1'h1 && rword === {CLS_USER, 6'h00}); k++) step;
    chk(k < 12000, 1'h1, "own word on line");
    if (k == 12000) complete_run;
    chk(rbad, 0, "frame format");
  endtask : t_serial

  task t_user;
    rst(4'hF);
    send(2, {CLS_USER, 6'h05}, 1'h0);
    wait_usr;
    chk({umod, ucode}, {2'h2, 6'h05}, "input user event");
    chk({out, halt}, {ctl, 1'h0}, "no trip on user");
    step;
    chk(uvld, 1'h0, "pulse one cycle");
    send(0, {CLS_USER, 6'h09}, 1'h0);
    wait_usr;
    chk({umod, ucode, out}, {2'h0, 6'h09, ctl}, "output user event");
    lnk[3] = 1'h0;
    // let the previous pulse go before looking for the link event
    step;
    wait_usr;
    chk({umod, ucode, halt}, {2'h3, 6'h3F, 1'h0}, "input link lost");
    lnk[1] = 1'h0;
    repeat (3) step;
    chk({halt, out}, 5'h10, "output link lost");
    lnk = 4'hF;
    repeat (5) step;
    chk({halt, out}, 5'h10, "halt holds");
  endtask : t_user

  task t_mid;
    rst(4'hF);
    send(1, {CLS_MID, 6'h11}, 1'h0);
    repeat (2) step;
    chk({msafe, out}, 8'h2D, "mid class module safe");
    chk({gen, alarm, halt}, 3'h6, "mid class alarm");
    send(1, {CLS_USER, 6'h01}, 1'h0);
    step;
    send(0, {CLS_SEV, 6'h02}, 1'h0);
    repeat (2) step;
    chk({msafe, out}, 8'h3C, "severe module safe");
    chk(halt, 1'h0, "module halts itself");
  endtask : t_mid

  task t_own;
    for (int k = 0; k < 3; k++) begin
      rst(4'hF);
      {pl, ifst, hw} = 3'h1 << k;
      send(2, {CLS_USER, 6'h03}, 1'h0);
      {pl, ifst, hw} = 3'h0;
      repeat (3) step;
      chk({halt, gen, out}, 6'h30, "own fault trips");
      repeat (20) step;
      chk({halt, out}, 5'h10, "halt kept");
    end
    rst(4'hF);
    chk({halt, out}, {1'h0, ctl}, "reset leaves halt");
  endtask : t_own

  task t_par;
    rst(4'hF);
    send(2, {CLS_NONE, 6'h00}, 1'h1);
    repeat (3) step;
    chk({halt, gen, out}, 6'h30, "parity fault trips");
  endtask : t_par

  task t_unqual;
    rst(4'hB);
    repeat (50) step;
    chk({out, halt, gen}, 6'h01, "unqualified hold");
    rst(4'hF);
  endtask : t_unqual

  initial begin
    repeat (100000) @(posedge clk);
    n_fail++;
    $display("ERROR %0t run limit", $time);
    complete_run;
  end

  initial begin
    t_startup;
    t_serial;
    t_user;
    t_mid;
    t_own;
    t_par;
    t_unqual;
    complete_run;
  end
endmodule : tb
